// [design/synth_cfg_map.svh]
/*
  Field positions, select codes and reset values of the
  configuration bank.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef SYNTH_CFG_MAP_SVH
`define SYNTH_CFG_MAP_SVH

// ==================================================================
// word framing
`define CFG_WORD_BITS 32
`define CFG_SEL_HI 3
`define CFG_SEL_LO 0

// ==================================================================
// register select codes
`define SEL_FREQUENCY 4'h0
`define SEL_CHARGE_PUMP 4'h4
`define SEL_FIXED_A 4'h5
`define SEL_OUTPUT_BLEED 4'h6
`define SEL_LOCK_SYNC 4'h7
`define SEL_FIXED_B 4'h8
`define SEL_CAL_TIMING 4'h9

// ==================================================================
// charge pump double-buffer bit
`define CP_DBUF_BIT 14

// ==================================================================
// output and bleed control fields
`define OB_POLARITY_BIT 31
`define OB_GATED_BIT 30
`define OB_NEG_BLEED_BIT 29
`define OB_FB_DIRECT_BIT 24
`define OB_DIV_HI 23
`define OB_DIV_LO 21
`define OB_BLEED_HI 20
`define OB_BLEED_LO 13
`define OB_MUTE_BIT 11
`define OB_AUX_DIS_BIT 10
`define OB_MAIN_EN_BIT 6
`define OB_POWER_HI 5
`define OB_POWER_LO 4

// ==================================================================
// lock and synchronisation fields
`define LS_EDGE_BIT 27
`define LS_SYNC_BIT 25
`define LS_COUNT_HI 9
`define LS_COUNT_LO 8
`define LS_LOL_BIT 7
`define LS_WIN_HI 6
`define LS_WIN_LO 5
`define LS_INT_MODE_BIT 4

// ==================================================================
// calibration timing fields
`define CT_BAND_DIV_HI 31
`define CT_BAND_DIV_LO 24
`define CT_TIMEOUT_HI 23
`define CT_TIMEOUT_LO 14
`define CT_LEVEL_HI 13
`define CT_LEVEL_LO 9

// ==================================================================
// reset values
`define RST_FIXED_A 32'h0000_0005
`define RST_OUTPUT_BLEED 32'h0000_0006
`define RST_LOCK_SYNC 32'h0000_0007
`define RST_FIXED_B 32'h0000_0008
`define RST_CAL_TIMING 32'h0000_0009

`endif

// [design/synth_cfg_pkg.sv]
/*
  Types shared by the configuration bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package synth_cfg_pkg;

    // effective lock window
    typedef enum logic [2:0] {
        WIN_5P0NS,
        WIN_6P0NS,
        WIN_8P0NS,
        WIN_12P0NS,
        WIN_INT_2P9NS
    } lock_window_t;

    // load commit sequencing
    typedef enum logic [0:0] {
        CMT_IDLE,
        CMT_WAIT_REF
    } commit_state_t;

endpackage

// [design/serial_word_shifter.sv]
/*
  Serial word shifter: shifts data on serial clock rises and
  presents the last word when the strobe rises after a full word.
  Assumes its inputs are already synchronised to the system clock.
*/
`include "synth_cfg_map.svh"

module serial_word_shifter
    import synth_cfg_pkg::*;
#(
    parameter int WORD_BITS = `CFG_WORD_BITS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // synchronised pins
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    // assembled word
    output logic word_valid_o,
    output logic [WORD_BITS-1:0] word_o
);

    logic ser_clk_prev;
    logic load_prev;
    logic [WORD_BITS-1:0] shift;
    logic [5:0] bit_count;
    logic clk_rise;
    logic load_rise;

    assign clk_rise = ser_clk_i & ~ser_clk_prev;
    assign load_rise = load_strobe_i & ~load_prev;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ser_clk_prev <= 1'b0;
            load_prev <= 1'b0;
        end else begin
            ser_clk_prev <= ser_clk_i;
            load_prev <= load_strobe_i;
        end
    end

    // saturating count: long bursts keep their last word
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift <= '0;
            bit_count <= 6'h00;
        end else if (load_rise) begin
            bit_count <= 6'h00;
        end else if (clk_rise && !load_strobe_i) begin
            shift <= {shift[WORD_BITS-2:0], ser_data_i};
            if (bit_count < 6'(WORD_BITS)) begin
                bit_count <= bit_count + 6'h01;
            end
        end
    end

    // short words are dropped at the strobe
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_valid_o <= 1'b0;
            word_o <= '0;
        end else begin
            word_valid_o <= load_rise && (bit_count == 6'(WORD_BITS));
            if (load_rise && (bit_count == 6'(WORD_BITS))) begin
                word_o <= shift;
            end
        end
    end

endmodule // serial_word_shifter

// [design/synth_output_lock_config_regs.sv]
/*
  Configuration bank for words 5 to 9 of a serial synthesizer:
  fixed words, output and bleed control, lock and load synchronisation,
  and calibration timing. Also watches words 0 and 4 for double buffering.
  Assumes the serial pins, reference clock and lock detect are asynchronous
  to CLK_SYS_I and slow against its period.

// Functional notes
// - select 0110 loads output and bleed control
// - double buffered divider waits for frequency word
// - gated bleed holds currents until lock
// - negative bleed bit turns constant bleed on
// - feedback select picks oscillator or divider
// - three-bit field picks output divider ratio
// - eight-bit field sets bleed current level
// - mute until lock cuts output stage
// - aux output control bit is active low
// - main output enabled when bit is one
// - two bits choose main output power
// - select 0111 loads lock and sync control
// - load sync retimes strobe to reference edge
// - edge select picks rising or falling reference
// - two bits pick lock detect cycle count
// - loss-of-lock mode tolerates missing reference
// - lock window field, integer mode overrides
// - select 1001 loads calibration timing fields
*/
`include "synth_cfg_map.svh"

module synth_output_lock_config_regs
    import synth_cfg_pkg::*;
#(
    parameter int WORD_BITS = `CFG_WORD_BITS
) (
    // system clock and reset
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    // serial programming pins
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic LOAD_STROBE_I,
    // reference clock and digital lock detect
    input wire logic REF_CLK_I,
    input wire logic LOCK_DETECT_I,
    // bleed controls
    output logic BLEED_POLARITY_SEL_O,
    output logic BLEED_ON_O,
    output logic NEGATIVE_BLEED_ON_O,
    output logic [7:0] BLEED_LEVEL_O,
    // feedback and divider
    output logic FEEDBACK_DIRECT_SEL_O,
    output logic [2:0] OUTPUT_DIVIDER_SEL_O,
    // output stages
    output logic MAIN_OUTPUT_ON_O,
    output logic [1:0] MAIN_OUTPUT_POWER_O,
    output logic AUX_OUTPUT_ON_O,
    // lock detector setup
    output logic [1:0] LOCK_COUNT_SEL_O,
    output logic MISSING_REF_LOCK_MODE_O,
    output lock_window_t LOCK_WINDOW_O,
    // calibration timing
    output logic [7:0] BAND_DIVISION_VALUE_O,
    output logic [9:0] BAND_SELECT_TIMEOUT_O,
    output logic [4:0] LEVEL_CAL_TIMER_O,
    // held words and load status
    output logic [WORD_BITS-1:0] FIXED_CONFIG_WORD_A_O,
    output logic [WORD_BITS-1:0] FIXED_CONFIG_WORD_B_O,
    output logic LOAD_APPLIED_O
);

    // ==================================================================
    // helpers

    function automatic logic sel_is(input logic [WORD_BITS-1:0] word, input logic [3:0] code);
        sel_is = (word[`CFG_SEL_HI:`CFG_SEL_LO] == code);
    endfunction

    // ==================================================================
    // pin synchronisers

    localparam int N_SYNC = 5;
    localparam int S_SCLK = 0;
    localparam int S_SDATA = 1;
    localparam int S_LOAD = 2;
    localparam int S_REF = 3;
    localparam int S_LOCK = 4;

    logic [N_SYNC-1:0] sync_first;
    logic [N_SYNC-1:0] sync_second;
    logic ref_prev;
    logic ref_rise;
    logic ref_fall;
    logic lock_ok;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sync_first <= '0;
            sync_second <= '0;
        end else begin
            sync_first <= {LOCK_DETECT_I, REF_CLK_I, LOAD_STROBE_I, SER_DATA_I, SER_CLK_I};
            sync_second <= sync_first;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= sync_second[S_REF];
        end
    end

    assign ref_rise = sync_second[S_REF] & ~ref_prev;
    assign ref_fall = ~sync_second[S_REF] & ref_prev;
    assign lock_ok = sync_second[S_LOCK];

    // ==================================================================
    // word assembly

    logic word_valid;
    logic [WORD_BITS-1:0] shift_word;

    serial_word_shifter #(
        .WORD_BITS(WORD_BITS)
    ) u_shifter (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .ser_clk_i(sync_second[S_SCLK]),
        .ser_data_i(sync_second[S_SDATA]),
        .load_strobe_i(sync_second[S_LOAD]),
        .word_valid_o(word_valid),
        .word_o(shift_word)
    );

    // ==================================================================
    // stored registers

    logic [WORD_BITS-1:0] fixed_config_word_a;
    logic [WORD_BITS-1:0] output_bleed_control;
    logic [WORD_BITS-1:0] lock_sync_control;
    logic [WORD_BITS-1:0] fixed_config_word_b;
    logic [WORD_BITS-1:0] calibration_timing;
    logic dbuf_en;

    logic load_sync_en;
    logic sync_edge_sel;
    logic sel_ref_edge;

    assign load_sync_en = lock_sync_control[`LS_SYNC_BIT];
    assign sync_edge_sel = lock_sync_control[`LS_EDGE_BIT];
    // 0 picks the rising reference edge
    assign sel_ref_edge = sync_edge_sel ? ref_fall : ref_rise;

    // ==================================================================
    // load commit, optionally retimed to the reference

    commit_state_t cmt_state;
    logic [WORD_BITS-1:0] held_word;
    logic commit_stb;
    logic [WORD_BITS-1:0] commit_word;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cmt_state <= CMT_IDLE;
            held_word <= '0;
        end else begin
            case (cmt_state)
                CMT_IDLE: begin
                    if (word_valid && load_sync_en) begin
                        held_word <= shift_word;
                        cmt_state <= CMT_WAIT_REF;
                    end
                end
                CMT_WAIT_REF: begin
                    // newer word flushes the held one
                    if (word_valid) begin
                        held_word <= shift_word;
                    end else if (sel_ref_edge) begin
                        cmt_state <= CMT_IDLE;
                    end
                end
                default: begin
                    cmt_state <= CMT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            commit_stb <= 1'b0;
            commit_word <= '0;
        end else begin
            commit_stb <= 1'b0;
            if (cmt_state == CMT_IDLE && word_valid && !load_sync_en) begin
                commit_stb <= 1'b1;
                commit_word <= shift_word;
            end else if (cmt_state == CMT_WAIT_REF && (word_valid || sel_ref_edge)) begin
                commit_stb <= 1'b1;
                commit_word <= held_word;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            LOAD_APPLIED_O <= 1'b0;
        end else begin
            LOAD_APPLIED_O <= commit_stb;
        end
    end

    // ==================================================================
    // register writes; reserved bits kept as written

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fixed_config_word_a <= `RST_FIXED_A;
            fixed_config_word_b <= `RST_FIXED_B;
        end else if (commit_stb) begin
            if (sel_is(commit_word, `SEL_FIXED_A)) begin
                fixed_config_word_a <= commit_word;
            end
            if (sel_is(commit_word, `SEL_FIXED_B)) begin
                fixed_config_word_b <= commit_word;
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            output_bleed_control <= `RST_OUTPUT_BLEED;
        end else if (commit_stb && sel_is(commit_word, `SEL_OUTPUT_BLEED)) begin
            output_bleed_control <= commit_word;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            lock_sync_control <= `RST_LOCK_SYNC;
        end else if (commit_stb && sel_is(commit_word, `SEL_LOCK_SYNC)) begin
            lock_sync_control <= commit_word;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            calibration_timing <= `RST_CAL_TIMING;
        end else if (commit_stb && sel_is(commit_word, `SEL_CAL_TIMING)) begin
            calibration_timing <= commit_word;
        end
    end

    // only the double-buffer bit of the charge pump word is kept here
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            dbuf_en <= 1'b0;
        end else if (commit_stb && sel_is(commit_word, `SEL_CHARGE_PUMP)) begin
            dbuf_en <= commit_word[`CP_DBUF_BIT];
        end
    end

    // ==================================================================
    // output divider, double buffered on demand

    logic [2:0] active_div;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            active_div <= 3'(`RST_OUTPUT_BLEED >> `OB_DIV_LO);
        end else if (commit_stb) begin
            if (sel_is(commit_word, `SEL_OUTPUT_BLEED) && !dbuf_en) begin
                active_div <= commit_word[`OB_DIV_HI:`OB_DIV_LO];
            end else if (sel_is(commit_word, `SEL_FREQUENCY)) begin
                // buffered value goes live with the frequency word
                active_div <= output_bleed_control[`OB_DIV_HI:`OB_DIV_LO];
            end
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            OUTPUT_DIVIDER_SEL_O <= 3'h0;
            FEEDBACK_DIRECT_SEL_O <= 1'b0;
        end else begin
            OUTPUT_DIVIDER_SEL_O <= active_div;
            FEEDBACK_DIRECT_SEL_O <= output_bleed_control[`OB_FB_DIRECT_BIT];
        end
    end

    // ==================================================================
    // bleed current control

    logic gated_bleed_en;
    logic bleed_allowed;

    assign gated_bleed_en = output_bleed_control[`OB_GATED_BIT];
    // lock detect must be running upstream or gated bleed never opens
    assign bleed_allowed = ~gated_bleed_en | lock_ok;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            BLEED_POLARITY_SEL_O <= 1'b0;
            BLEED_ON_O <= 1'b0;
            NEGATIVE_BLEED_ON_O <= 1'b0;
            BLEED_LEVEL_O <= 8'h00;
        end else begin
            BLEED_POLARITY_SEL_O <= output_bleed_control[`OB_POLARITY_BIT];
            BLEED_ON_O <= bleed_allowed;
            NEGATIVE_BLEED_ON_O <= output_bleed_control[`OB_NEG_BLEED_BIT] & bleed_allowed;
            BLEED_LEVEL_O <= output_bleed_control[`OB_BLEED_HI:`OB_BLEED_LO];
        end
    end

    // ==================================================================
    // output stages

    logic muted;

    assign muted = output_bleed_control[`OB_MUTE_BIT] & ~lock_ok;

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            MAIN_OUTPUT_ON_O <= 1'b0;
            AUX_OUTPUT_ON_O <= 1'b0;
            MAIN_OUTPUT_POWER_O <= 2'h0;
        end else begin
            MAIN_OUTPUT_ON_O <= output_bleed_control[`OB_MAIN_EN_BIT] & ~muted;
            AUX_OUTPUT_ON_O <= ~output_bleed_control[`OB_AUX_DIS_BIT] & ~muted;
            MAIN_OUTPUT_POWER_O <= output_bleed_control[`OB_POWER_HI:`OB_POWER_LO];
        end
    end

    // ==================================================================
    // lock detector setup

    lock_window_t next_window;

    always_comb begin
        if (lock_sync_control[`LS_INT_MODE_BIT]) begin
            next_window = WIN_INT_2P9NS;
        end else begin
            next_window = lock_window_t'({1'b0, lock_sync_control[`LS_WIN_HI:`LS_WIN_LO]});
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            LOCK_COUNT_SEL_O <= 2'h0;
            MISSING_REF_LOCK_MODE_O <= 1'b0;
            LOCK_WINDOW_O <= WIN_5P0NS;
        end else begin
            LOCK_COUNT_SEL_O <= lock_sync_control[`LS_COUNT_HI:`LS_COUNT_LO];
            MISSING_REF_LOCK_MODE_O <= lock_sync_control[`LS_LOL_BIT];
            LOCK_WINDOW_O <= next_window;
        end
    end

    // ==================================================================
    // calibration timing and held words

    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            BAND_DIVISION_VALUE_O <= 8'h00;
            BAND_SELECT_TIMEOUT_O <= 10'h000;
            LEVEL_CAL_TIMER_O <= 5'h00;
        end else begin
            BAND_DIVISION_VALUE_O <= calibration_timing[`CT_BAND_DIV_HI:`CT_BAND_DIV_LO];
            BAND_SELECT_TIMEOUT_O <= calibration_timing[`CT_TIMEOUT_HI:`CT_TIMEOUT_LO];
            LEVEL_CAL_TIMER_O <= calibration_timing[`CT_LEVEL_HI:`CT_LEVEL_LO];
        end
    end

    // fixed words only held; host owns content
    always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
        if (!NRST_I) begin
            FIXED_CONFIG_WORD_A_O <= `RST_FIXED_A;
            FIXED_CONFIG_WORD_B_O <= `RST_FIXED_B;
        end else begin
            FIXED_CONFIG_WORD_A_O <= fixed_config_word_a;
            FIXED_CONFIG_WORD_B_O <= fixed_config_word_b;
        end
    end

endmodule // synth_output_lock_config_regs

// [tb/synth_cfg_chk.sv]
/*
  Port checker for the configuration bank, bound to its top module.
  Assumes the design's package is compiled first.
*/
module synth_cfg_chk
    import synth_cfg_pkg::*;
#(
    parameter int WORD_BITS = 32
) (
    // clock, reset and pins
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic SER_CLK_I,
    input wire logic SER_DATA_I,
    input wire logic LOAD_STROBE_I,
    input wire logic REF_CLK_I,
    input wire logic LOCK_DETECT_I,
    // design outputs
    input wire logic BLEED_POLARITY_SEL_O,
    input wire logic BLEED_ON_O,
    input wire logic NEGATIVE_BLEED_ON_O,
    input wire logic [7:0] BLEED_LEVEL_O,
    input wire logic FEEDBACK_DIRECT_SEL_O,
    input wire logic [2:0] OUTPUT_DIVIDER_SEL_O,
    input wire logic MAIN_OUTPUT_ON_O,
    input wire logic [1:0] MAIN_OUTPUT_POWER_O,
    input wire logic AUX_OUTPUT_ON_O,
    input wire logic [1:0] LOCK_COUNT_SEL_O,
    input wire logic MISSING_REF_LOCK_MODE_O,
    input wire lock_window_t LOCK_WINDOW_O,
    input wire logic [7:0] BAND_DIVISION_VALUE_O,
    input wire logic [9:0] BAND_SELECT_TIMEOUT_O,
    input wire logic [4:0] LEVEL_CAL_TIMER_O,
    input wire logic [WORD_BITS-1:0] FIXED_CONFIG_WORD_A_O,
    input wire logic [WORD_BITS-1:0] FIXED_CONFIG_WORD_B_O,
    input wire logic LOAD_APPLIED_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);

    // ==================================================================
    // assertions
    chk_pulse_one_cycle: assert property (LOAD_APPLIED_O |=> !LOAD_APPLIED_O)
        else $error("long load pulse");
    chk_neg_needs_bleed: assert property (NEGATIVE_BLEED_ON_O |-> BLEED_ON_O)
        else $error("neg bleed while held");
    chk_bleed_after_lock: assert property (LOCK_DETECT_I [*8] |-> BLEED_ON_O)
        else $error("bleed off after lock");
    chk_stages_steady: assert property (LOCK_DETECT_I [*8] ##0 !LOAD_APPLIED_O
        |=> $stable(MAIN_OUTPUT_ON_O) && $stable(AUX_OUTPUT_ON_O))
        else $error("stage moved");
    chk_level_by_load: assert property ($changed(BLEED_LEVEL_O) |-> $past(LOAD_APPLIED_O))
        else $error("level moved");
    chk_divider_by_load: assert property (!$stable(OUTPUT_DIVIDER_SEL_O)
        |-> $past(LOAD_APPLIED_O)) else $error("divider moved");
    chk_cal_by_load: assert property ($changed({BAND_DIVISION_VALUE_O,
        BAND_SELECT_TIMEOUT_O, LEVEL_CAL_TIMER_O}) |-> $past(LOAD_APPLIED_O))
        else $error("cal moved");
    chk_lock_by_load: assert property ($changed({LOCK_COUNT_SEL_O,
        MISSING_REF_LOCK_MODE_O, LOCK_WINDOW_O}) |-> $past(LOAD_APPLIED_O))
        else $error("lock setup moved");
    chk_fixed_by_load: assert property ($changed({FIXED_CONFIG_WORD_A_O,
        FIXED_CONFIG_WORD_B_O}) |-> $past(LOAD_APPLIED_O))
        else $error("fixed moved");
    chk_window_code: assert property (LOCK_WINDOW_O <= WIN_INT_2P9NS)
        else $error("bad window");
endmodule // synth_cfg_chk

bind synth_output_lock_config_regs synth_cfg_chk #(.WORD_BITS(WORD_BITS)) u_chk (.*);

// [tb/host_serial_model.sv]
/*
  Host controller model: shifts words out on the three-wire serial pins.
  Assumes the bench clock; every pin moves 1 ns after a rising edge.
*/
module host_serial_model (
    // bench clock
    input wire logic clk_i,
    // serial pins
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_strobe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        ser_clk_o = 1'b0;
        ser_data_o = 1'b1;
        load_strobe_o = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // msb first; strobe held high until next word
    task automatic send(input logic [31:0] w, input int nbits);
        load_strobe_o = 1'b0;
        hold(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data_o = w[i];
            hold(4);
            ser_clk_o = 1'b1;
            hold(4);
            ser_clk_o = 1'b0;
        end
        hold(4);
        load_strobe_o = 1'b1;
        // no pull on the data line: show the inverse once released
        ser_data_o = ~ser_data_o;
    endtask
endmodule // host_serial_model

// [tb/tb_top.sv]
/*
  Self-checking bench for the configuration bank.
  Assumes the host model drives the serial pins.
*/
`define CHECK(name, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("MISMATCH %s expected %h seen %h", name, exp, got); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, nrst, ser_clk, ser_data, strobe, ref_clk, ref_run, lock;
    logic pol, bleed_on, neg_on, fb_dir, main_on, aux_on, missing_ref_lock_mode, applied;
    logic [1:0] power, count;
    logic [2:0] div, window;
    logic [7:0] level, band_div;
    logic [9:0] timeout;
    logic [4:0] cal_timer;
    logic [31:0] fixed_a, fixed_b;
    int mismatches, tests_run, ref_cnt;
    typedef struct packed { logic [31:0] word; logic [31:0] exp; } row_t;
    row_t rows [12] = '{
        '{32'h00800025, 32'h00800025},
        '{32'h15596568, 32'h15596568},
        '{32'hb5b4a066, 32'h000f5a5e},
        '{32'h14478416, 32'h000423c1},
        '{32'h14ffe076, 32'h00047fff},
        '{32'h04000007, 32'h00000000},
        '{32'h040001a7, 32'h00000111},
        '{32'h04000247, 32'h00000202},
        '{32'h040003e7, 32'h00000313},
        '{32'h04000077, 32'h00000004},
        '{32'hc3a96c09, 32'h0c32a516},
        '{32'hfffffe09, 32'h0ff3ff1f}};

    synth_output_lock_config_regs dut (
        .CLK_SYS_I(clk), .NRST_I(nrst), .SER_CLK_I(ser_clk), .SER_DATA_I(ser_data),
        .LOAD_STROBE_I(strobe), .REF_CLK_I(ref_clk), .LOCK_DETECT_I(lock),
        .BLEED_POLARITY_SEL_O(pol), .BLEED_ON_O(bleed_on), .NEGATIVE_BLEED_ON_O(neg_on),
        .BLEED_LEVEL_O(level), .FEEDBACK_DIRECT_SEL_O(fb_dir), .OUTPUT_DIVIDER_SEL_O(div),
        .MAIN_OUTPUT_ON_O(main_on), .MAIN_OUTPUT_POWER_O(power), .AUX_OUTPUT_ON_O(aux_on),
        .LOCK_COUNT_SEL_O(count), .MISSING_REF_LOCK_MODE_O(missing_ref_lock_mode), .LOCK_WINDOW_O(window),
        .BAND_DIVISION_VALUE_O(band_div), .BAND_SELECT_TIMEOUT_O(timeout),
        .LEVEL_CAL_TIMER_O(cal_timer), .FIXED_CONFIG_WORD_A_O(fixed_a),
        .FIXED_CONFIG_WORD_B_O(fixed_b), .LOAD_APPLIED_O(applied));
    host_serial_model host (.clk_i(clk), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
        .load_strobe_o(strobe));

    // ==================================================================
    // clocks
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        ref_cnt <= ref_cnt + 1;
        if (ref_run && ref_cnt % 10 == 0) ref_clk <= #1 ~ref_clk;
    end

    // ==================================================================
    // helpers
    function automatic logic [31:0] view(input logic [3:0] sel);
        case (sel)
            4'h5: return fixed_a;
            4'h8: return fixed_b;
            4'h6: return {12'h0, pol, bleed_on, neg_on, fb_dir, 1'b0, div, level,
                main_on, aux_on, power};
            4'h7: return {22'h0, count, 3'b0, missing_ref_lock_mode, 1'b0, window};
            default: return {4'h0, band_div, 2'b0, timeout, 3'b0, cal_timer};
        endcase
    endfunction
    task automatic watch(input int n, input logic exp_pulse);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (applied === 1'b1) seen = 1'b1;
        end
        `CHECK("load pulse", exp_pulse, seen)
    endtask
    task automatic put(input logic [31:0] w, input int nbits, input logic exp_pulse);
        host.send(w, nbits);
        watch(12, exp_pulse);
        watch(2, 1'b0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==================================================================
    // sequence
    initial begin
        nrst = 1'b0;
        lock = 1'b0;
        ref_clk = 1'b0;
        ref_run = 1'b1;
        ref_cnt = 0;
        mismatches = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHECK("reset word6", 32'h00040004, view(4'h6))
        `CHECK("reset word7", 32'h0, view(4'h7))
        `CHECK("reset word9", 32'h0, view(4'h9))
        `CHECK("reset fixed a", 32'h5, view(4'h5))
        `CHECK("reset fixed b", 32'h8, view(4'h8))
        lock = 1'b1;
        foreach (rows[i]) begin
            put(rows[i].word, 32, 1'b1);
            `CHECK("row view", rows[i].exp, view(rows[i].word[3:0]))
        end
        put(32'hb5b4a066, 20, 1'b0);
        `CHECK("partial word", 32'h00047fff, view(4'h6))
        put(32'h00004004, 32, 1'b1);
        put(32'hb5b4a066, 32, 1'b1);
        `CHECK("divider held", 3'b111, div)
        `CHECK("level live", 8'ha5, level)
        put(32'h00000010, 32, 1'b1);
        `CHECK("divider after freq", 3'b101, div)
        put(32'h00000004, 32, 1'b1);
        lock = 1'b0;
        put(32'h74020846, 32, 1'b1);
        `CHECK("held off", 4'h0, {bleed_on, neg_on, main_on, aux_on})
        lock = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        `CHECK("after lock", 4'hf, {bleed_on, neg_on, main_on, aux_on})
        // ref held still
        ref_run = 1'b0;
        put(32'h06000007, 32, 1'b1);
        ref_clk = 1'b0;
        host.send(32'hc3a96c09, 32);
        watch(30, 1'b0);
        ref_clk = 1'b1;
        watch(8, 1'b1);
        `CHECK("synced word9", 32'h0c32a516, view(4'h9))
        host.send(32'h0e000007, 32);
        watch(20, 1'b0);
        ref_clk = 1'b0;
        watch(10, 1'b0);
        ref_clk = 1'b1;
        watch(8, 1'b1);
        ref_clk = 1'b0;
        host.send(32'hfffffe09, 32);
        watch(20, 1'b0);
        ref_clk = 1'b1;
        watch(10, 1'b0);
        ref_clk = 1'b0;
        watch(8, 1'b1);
        `CHECK("falling word9", 32'h0ff3ff1f, view(4'h9))
        ref_run = 1'b1;
        host.send(32'h04000007, 32);
        watch(30, 1'b1);
        close_out();
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        close_out();
    end
endmodule // tb_top
